// ===== dv/adc_host_model.sv
// Bus host model that drives the converter's start, select and enable pins.
`timescale 1ns/10ps
`default_nettype none
module adc_host_model
   import adc_ctrl_pkg::*;
(
   input wire logic clk,
   output host_pins_t pins
);
   // ==========================================
   // Spacing between starts and recovery time
   localparam int SPACING_CYC = 500;
   localparam int RECOVERY_CYC = 10;
   int cyc = 0;
   int last_start = -SPACING_CYC;

   // Free cycle count, used to keep start strobes apart.
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   // All pins inactive at time zero, synchronous unipolar setup.
   initial begin
      pins = 6'h3e;
   end

   // Levels change at the falling edge, away from the sampling edge.
   task automatic set_pins(input logic sync, input logic bip, input logic cs, input logic oe, input logic en);
      @(negedge clk);
      pins.sync_mode = sync;
      pins.bipolar_offset_input = bip;
      pins.cs_n = cs;
      pins.oe_n = oe;
      pins.done_flag_enable_n = en;
   endtask : set_pins

   // Select has settled and the read has recovered before the strobe falls.
   task automatic start_conv();
      repeat (RECOVERY_CYC) @(negedge clk);
      while (cyc - last_start < SPACING_CYC) @(negedge clk);
      pins.start_strobe_n = 1'b0;
      last_start = cyc;
   endtask : start_conv

   // The strobe is never left low, so only one conversion is asked for.
   task automatic release_strobe();
      @(negedge clk);
      pins.start_strobe_n = 1'b1;
   endtask : release_strobe
endmodule : adc_host_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the conversion controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import adc_ctrl_pkg::*;
;
   // ==========================================
   // Clock, reset and design signals
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   host_pins_t pins;
   logic [11:0] core_code = 12'h000;
   logic [11:0] result_lines;
   logic result_lines_oe;
   logic done_flag;
   logic done_flag_oe;
   logic hold_mode;
   logic sample_strobe;
   logic mode_sync = 1'b1;
   int bad_count = 0;
   int checks_done = 0;
   // Each entry is sync, bipolar, core code, expected result.
   logic [25:0] conv_table [4] = '{{2'b10, 12'ha5c, 12'ha5c}, {2'b01, 12'h000, 12'h800},
                                  {2'b11, 12'h7ff, 12'hfff}, {2'b11, 12'h800, 12'h000}};

   // Half-period inversion gives 100 MHz.
   always #5 clk = ~clk;

   adc_conv_ctrl u_adc_conv_ctrl (.clk(clk), .arst_n(arst_n), .pins(pins), .core_code(core_code),
      .result_lines(result_lines), .result_lines_oe(result_lines_oe), .done_flag(done_flag),
      .done_flag_oe(done_flag_oe), .hold_mode(hold_mode), .sample_strobe(sample_strobe));
   adc_host_model u_adc_host_model (.clk(clk), .pins(pins));

   // ==========================================
   // Helpers
   // Busy shows as a low flag in synchronous mode and as a driven flag otherwise.
   function automatic logic sig_of(input int k);
      if (k == 0) return sample_strobe;
      if (k == 1) return hold_mode;
      return mode_sync ? ~done_flag : done_flag_oe;
   endfunction : sig_of

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end
      else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Bounded wait; running out of cycles ends the run as a failure.
   task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
      n = 0;
      while (sig_of(k) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         bad_count++;
         $display("MISMATCH wait on %0d expected %b seen timeout", k, lvl);
         complete_run();
      end
   endtask : wait_for

   // One full conversion with the select level that the mode calls for.
   task automatic run_conv(input logic sync, input logic bip, input logic [11:0] code, input logic [11:0] exp);
      int n;
      int gap;
      u_adc_host_model.set_pins(sync, bip, ~sync, 1'b1, 1'b0);
      mode_sync = sync;
      u_adc_host_model.start_conv();
      wait_for(0, 1'b1, 20, n);
      check("hold_mode", 12'(hold_mode), 12'h001);
      check("busy", 12'(sig_of(2)), 12'h001);
      // The next channel is switched in once the sample strobe shows; the held sample is kept.
      core_code = code;
      u_adc_host_model.release_strobe();
      check("strobe_pulse", 12'(sample_strobe), 12'h000);
      wait_for(1, 1'b0, 400, n);
      check("busy_at_track", 12'(sig_of(2)), 12'h001);
      wait_for(2, 1'b0, 400, gap);
      check("track_lead", 12'(gap >= 100), 12'h001);
      check("result", result_lines, exp);
      check("hold_idle", 12'(hold_mode), 12'h000);
      check("flag_oe_idle", 12'(done_flag_oe), 12'(sync));
      $display("Test conversion %h done", code);
   endtask : run_conv

   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (1010) @(negedge clk);
      u_adc_host_model.set_pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (5) @(negedge clk);
      check("idle_flag", 12'(done_flag), 12'h001);
      check("idle_flag_oe", 12'(done_flag_oe), 12'h001);
      check("idle_hold", 12'(hold_mode), 12'h000);
      $display("Test idle done");
      // A deselected strobe in synchronous mode must not start anything.
      u_adc_host_model.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      u_adc_host_model.start_conv();
      repeat (30) @(negedge clk);
      check("no_start_hold", 12'(hold_mode), 12'h000);
      check("no_start_flag_oe", 12'(done_flag_oe), 12'h000);
      u_adc_host_model.release_strobe();
      $display("Test deselected start done");
      for (int i = 0; i < 4; i++) begin
         run_conv(conv_table[i][25], conv_table[i][24], conv_table[i][23:12], conv_table[i][11:0]);
      end
      // Result drivers follow select and output enable together; the flag driver follows select and its enable.
      u_adc_host_model.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      repeat (5) @(negedge clk);
      check("read_oe", 12'(result_lines_oe), 12'h001);
      check("read_data", result_lines, 12'h000);
      u_adc_host_model.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      repeat (5) @(negedge clk);
      check("read_oe_deselected", 12'(result_lines_oe), 12'h000);
      check("flag_oe_disabled", 12'(done_flag_oe), 12'h000);
      $display("Test read done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire

// ===== include/adc_ctrl_params.svh
// Timing counts and reset values of the conversion controller.
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
// ==========================================================
// Clock and times
`define CLK_PERIOD_NS 10
`define APERTURE_NS 20
`define TRACK_RETURN_NS 2000
`define CONV_NS 4000
`define SETTLE_NS 1000
`define POWERUP_NS 10000
// ==========================================================
// Cycle counts: least times round up, longest times round down
`define APERTURE_CYC ((`APERTURE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRACK_CYC (`TRACK_RETURN_NS / `CLK_PERIOD_NS)
`define CONV_CYC (`CONV_NS / `CLK_PERIOD_NS)
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYC ((`POWERUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ==========================================================
// Widths and reset values
`define CODE_W 12
`define CNT_W 11
`define RESULT_RST 12'h000
`endif

// ===== include/adc_ctrl_pkg.sv
// Types shared by the conversion controller.
package adc_ctrl_pkg;
   // Controller states.
   typedef enum logic [2:0] {
      ST_POWERUP = 3'b000,
      ST_IDLE = 3'b001,
      ST_APERTURE = 3'b010,
      ST_CONVERT = 3'b011,
      ST_LATCH = 3'b100
   } state_t;
   // Host-side pin levels, all active as named.
   typedef struct packed {
      logic cs_n;
      logic start_strobe_n;
      logic oe_n;
      logic done_flag_enable_n;
      logic sync_mode;
      logic bipolar_offset_input;
   } host_pins_t;
endpackage : adc_ctrl_pkg

// ===== verilog/adc_conv_ctrl.sv
// Conversion control, status flag and result output of a sampling converter.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_params.svh"

// What this block and its host do
// [R1] Synchronous mode: conversion starts only when chip select and start strobe are low.
// [R2] Host sets chip select low a setup time before the start strobe.
// [R3] Asynchronous mode: start strobe low starts a conversion, chip select ignored.
// [R4] Input is sampled at start strobe fall, held after aperture delay.
// [R5] Idle: done flag high, sample-hold tracking.
// [R6] On start: sample-hold holds, done flag goes low.
// [R7] Mid-conversion the sample-hold returns to track for the next sample.
// [R8] Done flag returns high at conversion end; result then readable.
// [R9] Track re-entered at least 1 us before next conversion can start.
// [R10] Host may switch input channel once done flag goes low.
// [R11] Unipolar gives straight binary, bipolar gives twos complement.
// [R12] Result lines driven when chip select and output enable both low.
// [R13] Bipolar major carry sits half a step below analog ground.
// [R14] Host spaces start strobes at least 5 us and never holds it low.
// [R15] Done flag enabled by its enable, plus chip select in synchronous mode.
// [R16] Host waits a recovery time after output enable rises before starting.
// [R17] Done flag low whole conversion; result latched before flag rises.
module adc_conv_ctrl
   import adc_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire host_pins_t pins,
   input wire logic [`CODE_W-1:0] core_code,
   output logic [`CODE_W-1:0] result_lines,
   output logic result_lines_oe,
   output logic done_flag,
   output logic done_flag_oe,
   output logic hold_mode,
   output logic sample_strobe
);

   // ==========================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   host_pins_t pins_meta_reg;
   host_pins_t pins_s;

   // Reset enters asynchronously but is released through two flops.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe_reg <= 2'b00;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_reg[1];

   // Every pin is an asynchronous level; only the second flop is read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_reg <= '1;
         pins_s <= '1;
      end else begin
         pins_meta_reg <= pins;
         pins_s <= pins_meta_reg;
      end
   end

   // ==========================================================
   // Start detection
   logic start_req;
   logic start_req_d_reg;
   logic start_fire;

   // Synchronous mode gates the strobe with chip select; asynchronous does not.
   // Edge detection means a strobe held low starts only one conversion.
   assign start_req = pins_s.sync_mode ? (!pins_s.cs_n && !pins_s.start_strobe_n) // R1
                                       : !pins_s.start_strobe_n; // R3
   assign start_fire = start_req && !start_req_d_reg; // R4

   // Previous start request level for edge detection.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_req_d_reg <= 1'b0;
      end else begin
         start_req_d_reg <= start_req;
      end
   end

   // ==========================================================
   // Conversion sequencer
   state_t state_reg;
   logic [`CNT_W-1:0] cnt_reg;
   logic eoc_reg;
   logic hold_reg;
   logic strobe_reg;
   logic [`CODE_W-1:0] result_reg;
   logic [`CODE_W-1:0] coded;

   // Bipolar twos complement is offset binary with the top bit inverted, which
   // puts the major carry half a step below ground as the core quantises.
   assign coded = {core_code[`CODE_W-1] ^ pins_s.bipolar_offset_input, core_code[`CODE_W-2:0]}; // R11 R13

   // State and cycle counter; starts during a conversion are ignored.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_POWERUP;
         cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_POWERUP: begin
               if (cnt_reg == `CNT_W'(`POWERUP_CYC - 1)) begin
                  state_reg <= ST_IDLE;
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            ST_IDLE: begin
               if (start_fire) begin
                  state_reg <= ST_APERTURE; // R1 R3
                  cnt_reg <= '0;
               end
            end
            ST_APERTURE: begin
               if (cnt_reg == `CNT_W'(`APERTURE_CYC - 1)) begin
                  state_reg <= ST_CONVERT; // R4
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            ST_CONVERT: begin
               if (cnt_reg == `CNT_W'(`CONV_CYC - 1)) begin
                  state_reg <= ST_LATCH;
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            ST_LATCH: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
               cnt_reg <= '0;
            end
         endcase
      end
   end

   // End-of-convert flag: low from the start edge until after the latch.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eoc_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && start_fire) begin
         eoc_reg <= 1'b0; // R6 R17
      end else if (state_reg == ST_LATCH) begin
         eoc_reg <= 1'b1; // R8
      end else if (state_reg == ST_POWERUP && cnt_reg == `CNT_W'(`POWERUP_CYC - 1)) begin
         eoc_reg <= 1'b1; // R5
      end
   end

   // Track/hold: hold after the aperture delay, track again mid-conversion so
   // the next sample settles well before the earliest permitted next start.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= 1'b0;
         if (state_reg == ST_APERTURE && cnt_reg == `CNT_W'(`APERTURE_CYC - 1)) begin
            hold_reg <= 1'b1; // R4 R6
            strobe_reg <= 1'b1;
         end else if (state_reg == ST_CONVERT && cnt_reg == `CNT_W'(`TRACK_CYC - 1)) begin
            hold_reg <= 1'b0; // R7 R9
         end
      end
   end

   // Result is latched one cycle before the flag rises.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= `RESULT_RST;
      end else if (state_reg == ST_CONVERT && cnt_reg == `CNT_W'(`CONV_CYC - 1)) begin
         result_reg <= coded; // R17 R11
      end
   end

   // ==========================================================
   // Output drivers
   logic res_oe_reg;
   logic flag_reg;
   logic flag_oe_reg;

   // Data lines and status flag enables; async flag is open drain, low only.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_oe_reg <= 1'b0;
         flag_reg <= 1'b0;
         flag_oe_reg <= 1'b0;
      end else begin
         res_oe_reg <= !pins_s.cs_n && !pins_s.oe_n; // R12
         if (pins_s.sync_mode) begin
            flag_reg <= eoc_reg;
            flag_oe_reg <= !pins_s.cs_n && !pins_s.done_flag_enable_n; // R15
         end else begin
            flag_reg <= 1'b0;
            flag_oe_reg <= !eoc_reg && !pins_s.done_flag_enable_n; // R15
         end
      end
   end

   assign result_lines = result_reg;
   assign result_lines_oe = res_oe_reg;
   assign done_flag = flag_reg;
   assign done_flag_oe = flag_oe_reg;
   assign hold_mode = hold_reg;
   assign sample_strobe = strobe_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_start;
      state_reg == ST_IDLE && start_fire;
   endsequence

   sequence s_aperture;
      (!eoc_reg && !hold_reg) ##2 hold_reg;
   endsequence

   a_start_hold_seq: assert property (s_start |=> s_aperture) // R6
      else $error("Start did not drop flag and hold after the aperture delay.");

   a_track_return_mid: assert property ($rose(hold_reg) |-> ##199 hold_reg ##1 !hold_reg) // R7
      else $error("Sample-hold did not return to track at the expected cycle.");

   a_conv_length_full: assert property (s_start |-> ##[404:404] $rose(eoc_reg)) // R17
      else $error("Conversion flag did not rise at the expected cycle.");

   a_flag_after_latch: assert property ($rose(eoc_reg) |-> $stable(result_reg)) // R8
      else $error("Result changed in the cycle the flag rose.");

   a_idle_track_mode: assert property (state_reg == ST_IDLE |-> eoc_reg && !hold_reg) // R5
      else $error("Idle without flag high and sample-hold tracking.");

   a_result_drive_gate: assert property (!pins_s.cs_n && !pins_s.oe_n |=> result_lines_oe) // R12
      else $error("Result lines not driven with chip select and output enable low.");

   a_done_gate_sync: assert property (pins_s.sync_mode && pins_s.cs_n |=> !done_flag_oe) // R15
      else $error("Done flag driven in synchronous mode without chip select.");

   a_async_start_cs: assert property (state_reg == ST_IDLE && !pins_s.sync_mode && $stable(pins_s.sync_mode) // R3
                                      && $fell(pins_s.start_strobe_n) |=> state_reg == ST_APERTURE)
      else $error("Asynchronous start strobe did not begin a conversion.");

   a_sync_needs_cs: assert property (state_reg == ST_IDLE && pins_s.sync_mode && pins_s.cs_n // R1
                                     |=> state_reg != ST_APERTURE)
      else $error("Synchronous conversion began without chip select.");

   // The cycle in which the finished code is taken into the output register.
   sequence s_latch;
      state_reg == ST_CONVERT && cnt_reg == `CNT_W'(`CONV_CYC - 1);
   endsequence

   // The sample strobe is a single-cycle pulse.
   a_strobe_single_pulse: assert property (sample_strobe |=> !sample_strobe) // R4
      else $error("Sample strobe stood longer than one cycle.");

   // The sample is taken in the same cycle that the sample-hold enters hold.
   a_strobe_with_hold: assert property ($rose(sample_strobe) |-> $rose(hold_mode)) // R4 R6
      else $error("Sample strobe and hold entry were not simultaneous.");

   // The flag stays low over the whole busy span, aperture included.
   a_busy_flag_low: assert property (state_reg == ST_APERTURE || state_reg == ST_CONVERT |-> !eoc_reg) // R17
      else $error("Flag rose while a conversion was in progress.");

   // The register takes the coded core value at the last conversion cycle.
   a_result_latch_end: assert property (s_latch |=> result_reg == $past(coded)) // R17
      else $error("Result register did not take the finished code.");

   // Bipolar coding flips only the top bit of the offset-binary core code.
   a_bipolar_msb_code: assert property (s_latch |=> result_reg[`CODE_W-1] == // R11 R13
                                        ($past(core_code[`CODE_W-1]) != $past(pins_s.bipolar_offset_input)))
      else $error("Result top bit does not match the selected coding.");

   // Synchronous mode shows the internal flag one cycle late.
   a_sync_flag_value: assert property (pins_s.sync_mode |=> done_flag == $past(eoc_reg)) // R5 R8
      else $error("Synchronous flag value does not follow the conversion state.");

   // Asynchronous mode only ever pulls the flag low; the pull-up makes the high.
   a_async_flag_low: assert property (!pins_s.sync_mode |=> !done_flag) // R15
      else $error("Asynchronous flag driven high.");

   // Asynchronous mode drives the flag only while converting and enabled.
   a_async_flag_busy: assert property (!pins_s.sync_mode && !pins_s.done_flag_enable_n // R15
                                       |=> done_flag_oe == !$past(eoc_reg))
      else $error("Asynchronous flag drive does not follow the busy state.");

   // Track resumes well before the earliest next start, which must wait for idle.
   a_track_lead_min: assert property ($fell(hold_reg) |-> ##100 state_reg == ST_CONVERT) // R9
      else $error("Track returned less than the settling time before the conversion end.");

endmodule : adc_conv_ctrl
`default_nettype wire
